// ### core/touch_adc_power_filter_config.sv
// Power, shared pin, filter and first conversion delay control of the touch converter
//
// How it works
// - Shutdown code powers everything down
// - Master mode sleeps until screen touch
// - Slave/single: converter on demand, clock kept
// - Code 10 keeps converter, bias, oscillator on
// - Bit 13 picks analog channel or pin
// - Bits 12..10: pin data, direction, polarity
// - Bit 9 picks ratiometric or single-ended
// - Averaging field sets averaged sample count
// - Median field sets median window size
// - Writing bit 4 resets digital logic
// - Delay field spans 128 us to 2.048 ms
// - Delay before position channels and first conversion
// - Mode codes: none, single, slave, master
// - Pin mode disables auxiliary/battery selections
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
module touch_adc_power_filter_config
    import touch_cfg_pkg::*;
#(
    parameter int unsigned FIRST_DELAY_CYCLES = FIRST_DELAY_STEP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] adc_mode,
    input wire logic touch_detected,
    input wire logic conv_request,
    input wire logic conv_settle,
    input wire logic conv_active,
    output logic conv_go,
    output power_s power,
    output filter_s filter,
    output logic single_ended_select,
    output logic aux_channel_enable,
    output logic soft_reset_pulse,
    input wire logic gpio_in,
    output logic gpio_out,
    output logic gpio_oe
);

    // Delay sequencer states
    typedef enum logic [2:0] {
        DLY_IDLE = 3'b001,
        DLY_SETTLE = 3'b010,
        DLY_GO = 3'b100
    } delay_e;

    logic [15:0] ctrl; // Control register contents
    delay_e state; // Delay sequencer state
    logic [3:0] delay_code; // Delay field latched at start
    logic [3:0] steps_left; // Remaining delay steps
    logic [19:0] tick; // Cycles within one step
    logic awake; // Converter has been through its power-up delay
    logic busy; // A delay or a conversion is in progress
    power_s next_power; // Decoded power enables
    logic bus_write; // Access-phase write
    logic bus_setup; // Setup-phase cycle
    logic [1:0] power_management_sel;
    logic pin_gpio_en;
    logic pin_data_value;
    logic pin_dir_in;
    logic pin_polarity;
    logic [1:0] average_count_sel;
    logic [1:0] median_size_sel;
    logic [3:0] first_delay_sel;
    logic pin_level; // Pin value as seen through polarity

    // Field views of the control register
    assign power_management_sel = ctrl[PM_LSB +: 2];
    assign pin_gpio_en = ctrl[PIN_GPIO_BIT];
    assign pin_data_value = ctrl[PIN_DATA_BIT];
    assign pin_dir_in = ctrl[PIN_DIR_BIT];
    assign pin_polarity = ctrl[PIN_POL_BIT];
    assign average_count_sel = ctrl[AVG_LSB +: 2];
    assign median_size_sel = ctrl[MED_LSB +: 2];
    assign first_delay_sel = ctrl[FCD_LSB +: 4];

    // Power decode from management code, mode, touch and activity
    function automatic power_s decode_power(
        input logic [1:0] pm,
        input logic [1:0] mode,
        input logic touch,
        input logic active
    );
        power_s p;
        p = '0;
        unique case (pm)
            PM_SHUTDOWN: begin
                p = '0;
            end
            PM_ALWAYS_ON: begin
                p.adc = 1'b1;
                p.osc = 1'b1;
                p.bias = 1'b1;
                p.temp = active;
            end
            PM_AUTO, PM_AUTO_ALT: begin
                if (mode == MODE_MASTER) begin
                    // Everything sleeps until a touch or work in flight
                    p.adc = touch | active;
                    p.osc = touch | active;
                    p.bias = touch | active;
                    p.temp = touch | active;
                end else begin
                    // Timing kept alive, converter woken on demand
                    p.adc = active;
                    p.osc = 1'b1;
                    p.bias = 1'b1;
                    p.temp = active;
                end
            end
        endcase
        return p;
    endfunction

    // Filter sizes from their codes
    function automatic filter_s decode_filter(input logic [1:0] avg, input logic [1:0] med);
        filter_s f;
        f = '0;
        f.median_n = (med == 2'h0) ? 5'h00 : 5'(5'h02 << med);
        f.average_n = 5'(5'h02 << avg);
        if (avg == 2'h0 && med == 2'h0) begin
            f.average_n = 5'h01;
        end
        return f;
    endfunction

    assign bus_setup = psel & ~penable;
    assign bus_write = psel & penable & pwrite;
    assign busy = (state != DLY_IDLE) | conv_active;
    assign next_power = decode_power(power_management_sel, adc_mode, touch_detected, busy);
    assign pin_level = pin_polarity ? gpio_in : ~gpio_in;

    // Zero wait states; unmapped addresses answer with an error
    assign pready = psel & penable;
    assign pslverr = psel & penable & (paddr != CTRL2_ADDR) & (paddr != STATUS_ADDR);

    // Control register write; a set reset bit restores defaults instead
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL2_RESET;
        end else if (bus_write && paddr == CTRL2_ADDR) begin
            if (pwdata[SOFT_RESET_BIT]) begin
                ctrl <= CTRL2_RESET;
            end else begin
                ctrl <= pwdata[15:0];
            end
        end
    end

    // One-cycle digital reset pulse after a reset write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= bus_write & (paddr == CTRL2_ADDR) & pwdata[SOFT_RESET_BIT];
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (bus_setup) begin
            prdata <= '0;
            if (paddr == CTRL2_ADDR) begin
                // Reset bit reads zero; input pin shows its level
                prdata[15:0] <= {ctrl[15:13], (pin_dir_in ? pin_level : pin_data_value),
                    ctrl[11:5], 1'b0, ctrl[3:0]};
            end else if (paddr == STATUS_ADDR) begin
                prdata[ST_POWER_LSB +: 4] <= power;
                prdata[ST_BUSY_BIT] <= busy;
                prdata[ST_PIN_BIT] <= gpio_in;
                prdata[ST_AWAKE_BIT] <= awake;
            end
        end
    end

    // Registered analog power enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power <= '0;
        end else if (soft_reset_pulse) begin
            power <= '0;
        end else begin
            power <= next_power;
        end
    end

    // Registered configuration outputs and shared pin drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter <= '0;
            single_ended_select <= 1'b0;
            aux_channel_enable <= 1'b0;
            gpio_out <= 1'b0;
            gpio_oe <= 1'b0;
        end else begin
            filter <= decode_filter(average_count_sel, median_size_sel);
            single_ended_select <= ctrl[SINGLE_BIT];
            aux_channel_enable <= ~pin_gpio_en;
            gpio_out <= pin_polarity ? pin_data_value : ~pin_data_value;
            gpio_oe <= pin_gpio_en & ~pin_dir_in;
        end
    end

    // Converter awake flag: cleared whenever it loses power
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            awake <= 1'b0;
        end else if (soft_reset_pulse || !power.adc) begin
            awake <= 1'b0;
        end else if (state == DLY_GO) begin
            awake <= 1'b1;
        end
    end

    // First conversion delay sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= DLY_IDLE;
            delay_code <= '0;
            steps_left <= '0;
            tick <= '0;
        end else if (soft_reset_pulse) begin
            state <= DLY_IDLE;
            delay_code <= '0;
            steps_left <= '0;
            tick <= '0;
        end else begin
            unique case (state)
                DLY_IDLE: begin
                    if (conv_request) begin
                        if (conv_settle || !awake) begin
                            // Settle screen or power up converter first
                            state <= DLY_SETTLE;
                            delay_code <= first_delay_sel;
                            steps_left <= first_delay_sel;
                            tick <= '0;
                        end else begin
                            state <= DLY_GO;
                        end
                    end
                end
                DLY_SETTLE: begin
                    // Each step lasts one 128 us period
                    if (tick == 20'(FIRST_DELAY_CYCLES - 1)) begin
                        tick <= '0;
                        if (steps_left == 4'h0) begin
                            state <= DLY_GO;
                        end else begin
                            steps_left <= steps_left - 4'h1;
                        end
                    end else begin
                        tick <= tick + 20'h00001;
                    end
                end
                DLY_GO: begin
                    state <= DLY_IDLE;
                end
            endcase
        end
    end

    // Conversion start strobe
    assign conv_go = (state == DLY_GO);

    // Helper: cycles spent in the settle state
    logic [19:0] settle_count;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_count <= '0;
        end else if (state == DLY_SETTLE) begin
            settle_count <= settle_count + 20'h00001;
        end else begin
            settle_count <= '0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Power decode checks
    chk_full_shutdown: assert property (
        (power_management_sel == PM_SHUTDOWN) |=> (power == '0 || $past(soft_reset_pulse)))
        else $error("shutdown code left analog power on");

    chk_master_sleep: assert property (
        (power_management_sel == PM_AUTO && adc_mode == MODE_MASTER && !touch_detected && !busy)
        |=> (power == '0))
        else $error("master mode idle without touch but powered");

    chk_master_wake: assert property (
        (power_management_sel == PM_AUTO && adc_mode == MODE_MASTER && touch_detected && !soft_reset_pulse)
        |=> (power.adc && power.osc && power.bias))
        else $error("touch did not wake converter");

    chk_slave_timing: assert property (
        (power_management_sel[0] && (adc_mode == MODE_SLAVE || adc_mode == MODE_SINGLE)
        && !soft_reset_pulse) |=> (power.osc && power.bias && power.adc == $past(busy)))
        else $error("slave mode power wrong");

    chk_always_on: assert property (
        (power_management_sel == PM_ALWAYS_ON && !soft_reset_pulse) |=> (power.adc && power.osc && power.bias))
        else $error("always-on code dropped power");

    // Pin, channel and filter checks
    chk_aux_blocked: assert property (
        $past(pin_gpio_en) |-> !aux_channel_enable)
        else $error("auxiliary channel enabled while pin is gpio");

    chk_pin_drive: assert property (
        (pin_gpio_en && !pin_dir_in) ##1 (pin_gpio_en && !pin_dir_in)
        |-> gpio_oe && (gpio_out == ($past(pin_polarity) ~^ $past(pin_data_value))))
        else $error("gpio output drive wrong");

    chk_single_shot: assert property (
        (average_count_sel == 2'h0 && median_size_sel == 2'h0) |=> (filter.average_n == 5'h01))
        else $error("single measurement not selected");

    chk_median_size: assert property (
        (median_size_sel == 2'h3) |=> (filter.median_n == 5'h10))
        else $error("median size wrong");

    // Soft reset restores defaults and pulses once
    sequence reset_write_s;
        bus_write && paddr == CTRL2_ADDR && pwdata[SOFT_RESET_BIT];
    endsequence
    chk_soft_reset: assert property (
        reset_write_s |=> (ctrl == CTRL2_RESET && soft_reset_pulse) ##1 (state == DLY_IDLE))
        else $error("soft reset did not reset logic");

    // Delay length and entry
    sequence settle_start_s;
        state == DLY_IDLE && conv_request && (conv_settle || !awake) && !soft_reset_pulse;
    endsequence
    chk_settle_first: assert property (
        settle_start_s |=> (state == DLY_SETTLE && delay_code == $past(first_delay_sel)))
        else $error("delay skipped before settle or first conversion");

    chk_delay_length: assert property (
        (state == DLY_SETTLE) ##1 (state == DLY_GO)
        |-> ($past(settle_count) + 20'h00001 == 20'((delay_code + 1) * FIRST_DELAY_CYCLES)))
        else $error("first conversion delay length wrong");

endmodule

// ### core/touch_cfg_pkg.sv
// Constants, codes and carrier types of the power, pin and filter configuration block
package touch_cfg_pkg;

    // Clock and first conversion delay timing
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned FIRST_DELAY_STEP_NS = 128000;
    localparam int unsigned FIRST_DELAY_STEP_CYCLES = FIRST_DELAY_STEP_NS / CLK_PERIOD_NS;

    // Register indices and byte addresses on the bus
    localparam logic [7:0] CTRL2_INDEX = 8'h02;
    localparam logic [7:0] STATUS_INDEX = 8'h10;
    localparam logic [7:0] CTRL2_ADDR = {CTRL2_INDEX[5:0], 2'b00};
    localparam logic [7:0] STATUS_ADDR = {STATUS_INDEX[5:0], 2'b00};

    // Control register reset value and field positions
    localparam logic [15:0] CTRL2_RESET = 16'h4040;
    localparam int unsigned PM_LSB = 14;
    localparam int unsigned PIN_GPIO_BIT = 13;
    localparam int unsigned PIN_DATA_BIT = 12;
    localparam int unsigned PIN_DIR_BIT = 11;
    localparam int unsigned PIN_POL_BIT = 10;
    localparam int unsigned SINGLE_BIT = 9;
    localparam int unsigned AVG_LSB = 7;
    localparam int unsigned MED_LSB = 5;
    localparam int unsigned SOFT_RESET_BIT = 4;
    localparam int unsigned FCD_LSB = 0;

    // Status register field positions
    localparam int unsigned ST_POWER_LSB = 0;
    localparam int unsigned ST_BUSY_BIT = 4;
    localparam int unsigned ST_PIN_BIT = 5;
    localparam int unsigned ST_AWAKE_BIT = 6;

    // Power management codes
    localparam logic [1:0] PM_SHUTDOWN = 2'h0;
    localparam logic [1:0] PM_AUTO = 2'h1;
    localparam logic [1:0] PM_ALWAYS_ON = 2'h2;
    localparam logic [1:0] PM_AUTO_ALT = 2'h3;

    // Conversion mode codes
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_SLAVE = 2'h2;
    localparam logic [1:0] MODE_MASTER = 2'h3;

    // Analog power enables
    typedef struct packed {
        logic adc;
        logic osc;
        logic bias;
        logic temp;
    } power_s;

    // Filter sizes as sample counts
    typedef struct packed {
        logic [4:0] median_n;
        logic [4:0] average_n;
    } filter_s;

endpackage

// ### verification/testbench.sv
// Self-checking bench of the power, pin and filter configuration block
`timescale 1ns/100ps
module testbench
    import touch_cfg_pkg::*;
();
    localparam int unsigned DLY = 4; // Shortened delay step in cycles
    localparam logic [4:0] MED_T [4] = '{5'h00, 5'h04, 5'h08, 5'h10}; // Median window per code
    localparam logic [4:0] AVG_T [4] = '{5'h02, 5'h04, 5'h08, 5'h10}; // Average count per code
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] adc_mode = 2'h0;
    logic touch_detected = 1'b0;
    logic conv_request = 1'b0;
    logic conv_settle = 1'b0;
    logic conv_active = 1'b0;
    logic conv_go;
    power_s power;
    filter_s filter;
    logic single_ended_select;
    logic aux_channel_enable;
    logic soft_reset_pulse;
    logic gpio_in = 1'b0;
    logic gpio_out;
    logic gpio_oe;
    logic [31:0] rdata; // Data of the last bus read
    logic rerr; // Error flag of the last bus access
    logic [15:0] seed = 16'h0035; // Random source state
    logic [15:0] mdl; // Model of the control word
    int fail_count = 0;
    int comparisons = 0;
    int cnt;

    touch_adc_power_filter_config #(.FIRST_DELAY_CYCLES(DLY)) i_touch_adc_power_filter_config (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_mode(adc_mode), .touch_detected(touch_detected), .conv_request(conv_request),
        .conv_settle(conv_settle), .conv_active(conv_active), .conv_go(conv_go), .power(power),
        .filter(filter), .single_ended_select(single_ended_select),
        .aux_channel_enable(aux_channel_enable), .soft_reset_pulse(soft_reset_pulse),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe)
    );

    // Clock of 5 ns period
    initial begin
        forever #2.5 pclk = ~pclk;
    end

    // Next random value, sixteen bit shift register
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Expected power enables {adc, osc, bias, temp}
    function automatic logic [3:0] pwr(input logic [1:0] pm, input logic [1:0] md, input logic t, input logic b);
        case (pm)
            2'h0: return 4'h0;
            2'h2: return {3'h7, b};
            default: return (md == 2'h3) ? {4{t | b}} : {b, 1'b1, 1'b1, b};
        endcase
    endfunction

    // Compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    // One bus transfer, setup then access until ready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        forever begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Check the configuration outputs against the model word
    task automatic outs(input logic [15:0] c);
        repeat (2) @(posedge pclk);
        #1;
        chk(32'(filter), {22'h0, MED_T[c[6:5]], (c[8:5] == 4'h0) ? 5'h01 : AVG_T[c[8:7]]});
        chk(32'(single_ended_select), 32'(c[9]));
        chk(32'(aux_channel_enable), 32'(!c[13]));
        chk(32'(gpio_oe), 32'(c[13] & !c[11]));
        chk(32'(gpio_out), 32'(c[10] ? c[12] : !c[12]));
    endtask

    // Request a conversion and count cycles up to the start pulse
    task automatic conv(input logic settle, input int exp_n);
        int n;
        @(posedge pclk);
        conv_settle <= settle;
        conv_request <= 1'b1;
        @(posedge pclk);
        conv_request <= 1'b0;
        // A direct start shows its pulse in the cycle after the taking edge
        n = 1;
        #1;
        while (conv_go !== 1'b1 && n < 300) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(32'(n), 32'(exp_n));
    endtask

    // Print the counts and the verdict, then stop
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (8000) @(posedge pclk);
        fail_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL2_ADDR, 32'h0);
        chk(rdata, 32'h0000_4040);
        chk(32'(rerr), 32'h0);
        outs(16'h4040);
        // Unmapped place refuses and leaves the control word alone
        apb(1'b1, 8'h0C, 32'h0000_FFEF);
        chk(32'(rerr), 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rdata, 32'h0);
        apb(1'b0, CTRL2_ADDR, 32'h0);
        chk(rdata, 32'h0000_4040);
        // Random control words, read back and decoded
        repeat (10) begin
            seed = lfsr(seed);
            mdl = seed & 16'hF7EF;
            apb(1'b1, CTRL2_ADDR, {16'h0, mdl});
            apb(1'b0, CTRL2_ADDR, 32'h0);
            chk(rdata, {16'h0, mdl});
            outs(mdl);
        end
        // Every power code against every mode, touch and busy
        for (int pm = 0; pm < 4; pm++) begin
            for (int md = 0; md < 4; md++) begin
                for (int k = 0; k < 3; k++) begin
                    adc_mode <= 2'(md);
                    touch_detected <= (k == 1);
                    conv_active <= (k == 2);
                    apb(1'b1, CTRL2_ADDR, {16'h0, 2'(pm), 14'h0040});
                    repeat (3) @(posedge pclk);
                    #1;
                    chk(32'(power), 32'(pwr(2'(pm), 2'(md), k == 1, k == 2)));
                end
            end
        end
        conv_active <= 1'b0;
        touch_detected <= 1'b0;
        adc_mode <= MODE_SLAVE;
        // Settle delay for two codes, then an awake converter, then after power loss
        apb(1'b1, CTRL2_ADDR, 32'h0000_8042);
        conv(1'b1, 3 * DLY + 1);
        apb(1'b1, CTRL2_ADDR, 32'h0000_804F);
        conv(1'b1, 16 * DLY + 1);
        conv(1'b0, 1);
        apb(1'b1, CTRL2_ADDR, 32'h0000_0040);
        apb(1'b1, CTRL2_ADDR, 32'h0000_8040);
        conv(1'b0, DLY + 1);
        // Pin as input, level read through polarity
        for (int v = 0; v < 4; v++) begin
            gpio_in <= v[0];
            apb(1'b1, CTRL2_ADDR, {18'h0, 3'h5, v[1], 10'h0});
            apb(1'b0, CTRL2_ADDR, 32'h0);
            chk(32'(rdata[12]), 32'(v[1] ? v[0] : !v[0]));
            apb(1'b0, STATUS_ADDR, 32'h0);
            chk(32'(rdata[ST_PIN_BIT]), 32'(v[0]));
            chk(rdata & 32'hFFFF_FFDF, 32'h0);
        end
        // Soft reset restores the defaults with one pulse
        apb(1'b1, CTRL2_ADDR, 32'h0000_B7FF);
        cnt = 0;
        repeat (4) begin
            #1;
            cnt += int'(soft_reset_pulse === 1'b1);
            @(posedge pclk);
        end
        chk(32'(cnt), 32'h1);
        apb(1'b0, CTRL2_ADDR, 32'h0);
        chk(rdata, 32'h0000_4040);
        outs(16'h4040);
        print_verdict();
    end
endmodule
